//--- axil_regs.sv
module axil_regs
   import pte_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             wr_stb,
   output logic [7:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic             rd_stb,
   output logic [7:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_hit,
   input  wire logic        wr_hit
);
   logic       aw_have_r;
   logic       w_have_r;
   logic [7:0] aw_r;
   logic [31:0] w_r;
   logic [3:0] ws_r;
   logic       rd_pend_r;

   assign awready = !aw_have_r && !bvalid;
   assign wready  = !w_have_r && !bvalid;
   assign arready = !rd_pend_r && !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_r      <= 8'h00;
         w_r       <= 32'h0000_0000;
         ws_r      <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
         wr_stb    <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (awvalid && awready) begin
            aw_have_r <= 1'b1;
            aw_r      <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_r <= 1'b1;
            w_r      <= wdata;
            ws_r     <= wstrb;
         end
         if (aw_have_r && w_have_r) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            wr_stb    <= wr_hit && (ws_r == 4'hf);
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   assign wr_addr = aw_r;
   assign wr_data = w_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_pend_r <= 1'b0;
         rd_addr   <= 8'h00;
         rvalid    <= 1'b0;
         rdata     <= 32'h0000_0000;
         rresp     <= RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            rd_pend_r <= 1'b1;
            rd_addr   <= araddr;
         end
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            rvalid    <= 1'b1;
            rdata     <= rd_hit ? rd_data : 32'h0000_0000;
            rresp     <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
   assign rd_stb = rd_pend_r;
endmodule

//--- mem_model.sv
module mem_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             mem_ack,
   output logic [31:0]      mem_data = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [logic [31:0]];
   int          dly = 1;
   int          cnt;
   // entries are stored as written; unused data lines toggle every cycle
   always_ff @(posedge aclk) begin
      if (!aresetn || !mem_req || mem_ack || cnt < dly) begin
         cnt      <= (!aresetn || !mem_req || mem_ack) ? 0 : cnt + 1;
         mem_ack  <= 1'b0;
         mem_data <= ~mem_data;
      end else begin
         mem_ack  <= 1'b1;
         mem_data <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
      end
   end
endmodule

//--- page_entry_access_check.sv
// Contract
// - second-level thread_level clear means shared page, set means thread-level lookup follows.
// - bit 7 ignored in first-level and thread-level entries.
// - channel processor references need channel_io_ok set in the final entry.
// - older variant: bit 5 routes the frame to I/O address space.
// - entry_okay clear gives segment out-of-bounds error and system exception.
// - read with load_permit clear faults and loads fault_code_register.
// - write with store_permit clear faults and loads fault_code_register.
// - fetch with fetch_permit clear faults and loads fault_code_register.
// - valid entry with page_loaded clear raises a page fault exception.
// - page_loaded examined only when the entry is valid.
// - shared resident page: entry bits 31..12 form physical address upper 20 bits.
// - unshared: second-level bits 31..8 are the thread table base upper 24 bits.
// - newer variant: cache_bypass_flag keeps loads and stores out of data cache.
// - both variants walk two levels for shared, three for unshared pages.
// - thread table indexed by thread_number; thread entry is the final translation.
// - no permission checks on first-level or pointer second-level entries.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module page_entry_access_check
   import pte_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic            newer_variant,
   input  wire logic            req_valid,
   input  wire logic [31:0]     req_vaddr,
   input  wire logic [1:0]      req_kind,
   input  wire logic            req_channel,
   input  wire logic [TN_W-1:0] thread_number,
   output logic                 req_ready,
   output logic                 mem_req,
   output logic [31:0]          mem_addr,
   input  wire logic            mem_ack,
   input  wire logic [31:0]     mem_data,
   output logic                 done,
   output logic [31:0]          phys_addr,
   output logic                 io_space,
   output logic                 cache_bypass,
   output logic                 sys_exception,
   output logic [3:0]           fault_code,
   output logic                 irq
);
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_L1   = 5'b00010,
      S_L2   = 5'b00100,
      S_LT   = 5'b01000,
      S_END  = 5'b10000
   } state_t;

   state_t      state_r;
   logic [31:0] root_r;
   logic [31:0] va_r;
   logic [1:0]  kind_r;
   logic        chan_r;
   logic [TN_W-1:0] tn_r;
   logic        req_out_r;
   logic [3:0]  fault_code_register_r;
   logic [1:0]  status_r;
   logic [1:0]  mask_r;
   logic        io_r;
   logic        byp_r;
   logic        ev_done;
   logic        ev_fault;
   logic [3:0]  code_nxt;

   logic        wr_stb;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic        rd_stb;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_hit;
   logic        wr_hit;

   logic        d_okay;
   logic        d_loaded;
   logic        d_lvl;
   logic        d_io;
   logic        d_byp;
   logic        d_chan;
   logic [2:0]  d_perms;

   axil_regs u_regs (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .wr_stb  (wr_stb),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_stb  (rd_stb),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_hit  (rd_hit),
      .wr_hit  (wr_hit)
   );

   pte_decode u_dec (
      .entry         (mem_data),
      .newer_variant (newer_variant),
      .okay          (d_okay),
      .loaded        (d_loaded),
      .lvl_ind       (d_lvl),
      .io_space      (d_io),
      .bypass        (d_byp),
      .chan_ok       (d_chan),
      .perms         (d_perms)
   );

   // final-entry check: validity first, then residency, then access
   function automatic logic [3:0] final_check(input logic ok, input logic ld, input logic [2:0] pm,
                                              input logic [1:0] kind, input logic chan, input logic cok);
      if (!ok) return FC_SEGMENT;
      if (!ld) return FC_PAGE;
      if (chan && !cok) return FC_CHANNEL;
      if (kind == ACC_LOAD && !pm[2]) return FC_LOAD;
      if (kind == ACC_STORE && !pm[1]) return FC_STORE;
      if (kind == ACC_FETCH && !pm[0]) return FC_FETCH;
      return FC_NONE;
   endfunction

   always_comb begin
      code_nxt = FC_NONE;
      if (state_r == S_L1) begin
         // only validity and residency matter here; bit 7 and permissions unused
         if (!d_okay) code_nxt = FC_SEGMENT;
         else if (!d_loaded) code_nxt = FC_PAGE;
      end else if (state_r == S_L2 && d_okay && d_lvl) begin
         if (!d_loaded) code_nxt = FC_PAGE;
      end else begin
         code_nxt = final_check(d_okay, d_loaded, d_perms, kind_r, chan_r, d_chan);
      end
   end

   assign req_ready = 1'b0 == 1'b1 ? 1'b0 : (state_r == S_IDLE);

   // walk: level 1, level 2, optional thread level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r       <= S_IDLE;
         va_r          <= 32'h0000_0000;
         kind_r        <= ACC_LOAD;
         chan_r        <= 1'b0;
         tn_r          <= '0;
         req_out_r     <= 1'b0;
         mem_req       <= 1'b0;
         mem_addr      <= 32'h0000_0000;
         done          <= 1'b0;
         phys_addr     <= 32'h0000_0000;
         io_space      <= 1'b0;
         cache_bypass  <= 1'b0;
         sys_exception <= 1'b0;
         fault_code    <= FC_NONE;
      end else begin
         done          <= 1'b0;
         sys_exception <= 1'b0;
         mem_req       <= 1'b0;
         unique case (state_r)
            S_IDLE: begin
               if (req_valid) begin
                  va_r     <= req_vaddr;
                  kind_r   <= req_kind;
                  chan_r   <= req_channel;
                  tn_r     <= thread_number;
                  mem_req  <= 1'b1;
                  mem_addr <= {root_r[31:PAGE_SHIFT], req_vaddr[31:22], 2'b00};
                  state_r  <= S_L1;
               end
            end
            S_L1: begin
               if (!mem_ack) mem_req <= 1'b1;
               else if (code_nxt != FC_NONE) begin
                  sys_exception <= 1'b1;
                  fault_code    <= code_nxt;
                  state_r       <= S_END;
               end else begin
                  mem_req  <= 1'b1;
                  mem_addr <= {mem_data[31:PAGE_SHIFT], va_r[21:12], 2'b00};
                  state_r  <= S_L2;
               end
            end
            S_L2: begin
               if (!mem_ack) mem_req <= 1'b1;
               else if (code_nxt != FC_NONE) begin
                  sys_exception <= 1'b1;
                  fault_code    <= code_nxt;
                  state_r       <= S_END;
               end else if (d_lvl) begin
                  mem_req  <= 1'b1;
                  mem_addr <= {mem_data[31:TABLE_SHIFT], 8'h00} +
                              {24'h000000, tn_r, 2'b00};
                  state_r  <= S_LT;
               end else begin
                  done         <= 1'b1;
                  phys_addr    <= {mem_data[31:PAGE_SHIFT], va_r[11:0]};
                  io_space     <= d_io;
                  cache_bypass <= d_byp;
                  fault_code   <= FC_NONE;
                  state_r      <= S_END;
               end
            end
            S_LT: begin
               if (!mem_ack) mem_req <= 1'b1;
               else if (code_nxt != FC_NONE) begin
                  sys_exception <= 1'b1;
                  fault_code    <= code_nxt;
                  state_r       <= S_END;
               end else begin
                  done         <= 1'b1;
                  phys_addr    <= {mem_data[31:PAGE_SHIFT], va_r[11:0]};
                  io_space     <= d_io;
                  cache_bypass <= d_byp;
                  fault_code   <= FC_NONE;
                  state_r      <= S_END;
               end
            end
            S_END: state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   assign ev_done  = (state_r != S_IDLE) && (state_r != S_END) && mem_ack && code_nxt == FC_NONE &&
                     (state_r == S_LT || (state_r == S_L2 && !d_lvl));
   assign ev_fault = (state_r != S_IDLE) && (state_r != S_END) && mem_ack && code_nxt != FC_NONE;

   always_ff @(posedge aclk) begin
      if (!aresetn) fault_code_register_r <= FC_NONE;
      else if (ev_fault) fault_code_register_r <= code_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         root_r <= ROOT_RST;
         mask_r <= 2'b00;
      end else if (wr_stb) begin
         if (wr_addr == REG_ROOT) root_r <= wr_data;
         if (wr_addr == REG_MASK) mask_r <= wr_data[1:0];
      end
   end

   // set wins over the read-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) status_r <= 2'b00;
      else status_r <= ((rd_stb && rd_addr == REG_STATUS) ? 2'b00 : status_r) | {ev_fault, ev_done};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) irq <= 1'b0;
      else irq <= |(status_r & mask_r);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_r  <= 1'b0;
         byp_r <= 1'b0;
      end else if (done) begin
         io_r  <= io_space;
         byp_r <= cache_bypass;
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      unique case (rd_addr)
         REG_CTRL:   rd_data = {31'h0, newer_variant};
         REG_ROOT:   rd_data = root_r;
         REG_STATUS: rd_data = {30'h0, status_r};
         REG_MASK:   rd_data = {30'h0, mask_r};
         REG_FAULT:  rd_data = {28'h0, fault_code_register_r};
         REG_PADDR:  rd_data = phys_addr;
         REG_ATTR:   rd_data = {30'h0, byp_r, io_r};
         default: begin
            rd_data = 32'h0000_0000;
            rd_hit  = 1'b0;
         end
      endcase
   end
   assign wr_hit = (wr_addr == REG_ROOT) || (wr_addr == REG_MASK);

   property p_seg_fault;
      @(posedge aclk) disable iff (!aresetn)
      ((state_r != S_IDLE) && (state_r != S_END) && mem_ack && !mem_data[BIT_ENTRY_OKAY])
         |=> (sys_exception && fault_code == FC_SEGMENT);
   endproperty
   a_seg_fault: assert property (p_seg_fault) else $error("invalid entry not flagged");

   property p_load_fault;
      @(posedge aclk) disable iff (!aresetn)
      ((state_r == S_LT || (state_r == S_L2 && !mem_data[7])) && mem_ack && mem_data[4] && mem_data[0] &&
       !chan_r && kind_r == ACC_LOAD && !mem_data[3])
         |=> (sys_exception && fault_code_register_r == FC_LOAD);
   endproperty
   a_load_fault: assert property (p_load_fault) else $error("load fault code missing");

   property p_store_fault;
      @(posedge aclk) disable iff (!aresetn)
      ((state_r == S_LT || (state_r == S_L2 && !mem_data[7])) && mem_ack && mem_data[4] && mem_data[0] &&
       !chan_r && kind_r == ACC_STORE && !mem_data[2])
         |=> (sys_exception && fault_code == FC_STORE);
   endproperty
   a_store_fault: assert property (p_store_fault) else $error("store fault missing");

   property p_fetch_fault;
      @(posedge aclk) disable iff (!aresetn)
      ((state_r == S_LT || (state_r == S_L2 && !mem_data[7])) && mem_ack && mem_data[4] && mem_data[0] &&
       !chan_r && kind_r == ACC_FETCH && !mem_data[1])
         |=> (sys_exception && fault_code == FC_FETCH);
   endproperty
   a_fetch_fault: assert property (p_fetch_fault) else $error("fetch fault missing");

   property p_page_fault;
      @(posedge aclk) disable iff (!aresetn)
      ((state_r != S_IDLE) && (state_r != S_END) && mem_ack && mem_data[4] && !mem_data[0])
         |=> (sys_exception && fault_code == FC_PAGE);
   endproperty
   a_page_fault: assert property (p_page_fault) else $error("page fault missing");

   property p_shared_addr;
      @(posedge aclk) disable iff (!aresetn)
      (state_r == S_L2 && mem_ack && code_nxt == FC_NONE && !mem_data[7])
         |=> (done && phys_addr[31:12] == $past(mem_data[31:12]));
   endproperty
   a_shared_addr: assert property (p_shared_addr) else $error("shared frame address wrong");

   property p_thread_ptr;
      @(posedge aclk) disable iff (!aresetn)
      (state_r == S_L2 && mem_ack && code_nxt == FC_NONE && mem_data[7])
         |=> (mem_req && state_r == S_LT && mem_addr[31:8] == $past(mem_data[31:8]) && mem_addr[7:2] == tn_r);
   endproperty
   a_thread_ptr: assert property (p_thread_ptr) else $error("thread table pointer wrong");

   property p_bypass;
      @(posedge aclk) disable iff (!aresetn)
      (done && cache_bypass) |-> newer_variant;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass in older variant");

   property p_io;
      @(posedge aclk) disable iff (!aresetn)
      (done && io_space) |-> !newer_variant;
   endproperty
   a_io: assert property (p_io) else $error("io space in newer variant");

   property p_irq;
      @(posedge aclk) disable iff (!aresetn)
      (|(status_r & mask_r)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

//--- pte_decode.sv
module pte_decode
   import pte_pkg::*;
(
   input  wire logic [31:0] entry,
   input  wire logic        newer_variant,
   output logic             okay,
   output logic             loaded,
   output logic             lvl_ind,
   output logic             io_space,
   output logic             bypass,
   output logic             chan_ok,
   output logic [2:0]       perms
);
   always_comb begin
      okay     = entry[BIT_ENTRY_OKAY];
      loaded   = entry[BIT_PAGE_LOADED];
      lvl_ind  = entry[BIT_THREAD_LEVEL];
      io_space = !newer_variant && entry[BIT_ATTR5];
      bypass   = newer_variant && entry[BIT_ATTR5];
      chan_ok  = entry[BIT_CHANNEL_IO_OK];
      perms    = {entry[BIT_LOAD_PERMIT], entry[BIT_STORE_PERMIT], entry[BIT_FETCH_PERMIT]};
   end
endmodule

//--- pte_pkg.sv
package pte_pkg;
   // entry bit positions
   localparam int BIT_PAGE_LOADED   = 0;
   localparam int BIT_FETCH_PERMIT  = 1;
   localparam int BIT_STORE_PERMIT  = 2;
   localparam int BIT_LOAD_PERMIT   = 3;
   localparam int BIT_ENTRY_OKAY    = 4;
   localparam int BIT_ATTR5         = 5;
   localparam int BIT_CHANNEL_IO_OK = 6;
   localparam int BIT_THREAD_LEVEL  = 7;
   localparam int PAGE_SHIFT        = 12;
   localparam int TABLE_SHIFT       = 8;
   localparam int TN_W              = 6;
   // fault codes
   localparam logic [3:0] FC_NONE     = 4'h0;
   localparam logic [3:0] FC_SEGMENT  = 4'h1;
   localparam logic [3:0] FC_PAGE     = 4'h2;
   localparam logic [3:0] FC_LOAD     = 4'h3;
   localparam logic [3:0] FC_STORE    = 4'h4;
   localparam logic [3:0] FC_FETCH    = 4'h5;
   localparam logic [3:0] FC_CHANNEL  = 4'h6;
   // access kinds
   localparam logic [1:0] ACC_LOAD    = 2'h0;
   localparam logic [1:0] ACC_STORE   = 2'h1;
   localparam logic [1:0] ACC_FETCH   = 2'h2;
   // AXI4-Lite register byte addresses
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_ROOT    = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;
   localparam logic [7:0] REG_MASK    = 8'h0c;
   localparam logic [7:0] REG_FAULT   = 8'h10;
   localparam logic [7:0] REG_PADDR   = 8'h14;
   localparam logic [7:0] REG_ATTR    = 8'h18;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // status bits
   localparam int ST_DONE  = 0;
   localparam int ST_FAULT = 1;
   localparam logic [31:0] ROOT_RST = 32'h0000_0000;
endpackage

//--- tb.sv
module tb;
   import pte_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic            aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic            s_axi_arvalid = 0, s_axi_rready = 0, newer_variant = 0, req_valid = 0, req_channel = 0;
   logic [7:0]      s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]     s_axi_wdata = '0, req_vaddr = '0;
   logic [3:0]      s_axi_wstrb = 4'hf;
   logic [1:0]      req_kind = '0;
   logic [TN_W-1:0] thread_number = '0;
   logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_ready;
   logic            mem_req, mem_ack, done, io_space, cache_bypass, sys_exception, irq;
   logic [1:0]      s_axi_bresp, s_axi_rresp;
   logic [31:0]     s_axi_rdata, mem_addr, mem_data, phys_addr;
   logic [3:0]      fault_code;
   int              miscompares = 0, comparisons = 0;
   page_entry_access_check dut_u (.*);
   mem_model mem_u (.*);
   always #10 aclk = ~aclk;
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hold(input int n);
      if (n >= 60) begin
         miscompares++;
         summarize();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 60);
      hold(n);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 60);
      hold(n);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rst(input logic nv);
      aresetn <= 1'b0;
      newer_variant <= nv;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axw(REG_ROOT, 32'h0001_0000);
   endtask
   // va 0x00403abc: first level at root+4, second level at 0x0002000c, thread 5
   task automatic walk(input logic [31:0] l2, te, input logic [1:0] k, input logic ch,
                       input logic [3:0] fc, input logic [31:0] pa, input logic io, cb);
      int n = 0;
      mem_u.mem[32'h0001_0004] = 32'h0002_0091;
      mem_u.mem[32'h0002_000c] = l2;
      mem_u.mem[{l2[31:8], 8'h00} + 32'h14] = te;
      req_vaddr <= 32'h0040_3abc;
      req_kind <= k;
      req_channel <= ch;
      thread_number <= 6'h05;
      req_valid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!req_ready && n < 60);
      hold(n);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!done && !sys_exception && n < 60);
      hold(n);
      chk(sys_exception, fc != FC_NONE);
      if (fc != FC_NONE) chk(fault_code, fc);
      if (fc == FC_NONE) begin
         chk(phys_addr, pa);
         chk({io_space, cache_bypass}, {io, cb});
      end
   endtask
   task automatic sc_paths();
      walk(32'h0055_501f, '0, ACC_LOAD, 1'b0, FC_NONE, 32'h0055_5abc, 1'b0, 1'b0);
      walk(32'h0003_0391, 32'h0077_709f, ACC_FETCH, 1'b0, FC_NONE, 32'h0077_7abc, 1'b0, 1'b0);
      walk(32'h0055_505f, '0, ACC_STORE, 1'b1, FC_NONE, 32'h0055_5abc, 1'b0, 1'b0);
   endtask
   task automatic sc_faults();
      walk(32'h0055_5017, '0, ACC_LOAD, 1'b0, FC_LOAD, '0, 1'b0, 1'b0);
      walk(32'h0055_501b, '0, ACC_STORE, 1'b0, FC_STORE, '0, 1'b0, 1'b0);
      walk(32'h0055_501d, '0, ACC_FETCH, 1'b0, FC_FETCH, '0, 1'b0, 1'b0);
      walk(32'h0055_500e, '0, ACC_LOAD, 1'b0, FC_SEGMENT, '0, 1'b0, 1'b0);
      walk(32'h0055_501e, '0, ACC_LOAD, 1'b0, FC_PAGE, '0, 1'b0, 1'b0);
      walk(32'h0055_501f, '0, ACC_LOAD, 1'b1, FC_CHANNEL, '0, 1'b0, 1'b0);
   endtask
   task automatic sc_regs();
      logic [31:0] d;
      logic [1:0]  r;
      logic        i0;
      axr(REG_ROOT, d, r);
      chk(d, 32'h0001_0000);
      axw(REG_MASK, 32'h0000_0003);
      axr(REG_STATUS, d, r);
      walk(32'h0055_5017, '0, ACC_LOAD, 1'b0, FC_LOAD, '0, 1'b0, 1'b0);
      repeat (3) @(posedge aclk);
      i0 = irq;
      axw(REG_MASK, 32'h0000_0000);
      repeat (3) @(posedge aclk);
      chk(i0, 1'b1);
      chk(irq, 1'b0);
      axr(REG_FAULT, d, r);
      chk(d, FC_LOAD);
      axr(REG_STATUS, d, r);
      chk(d[ST_FAULT], 1'b1);
      axr(REG_STATUS, d, r);
      chk(d, '0);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      axr(8'h40, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      axr(REG_CTRL, d, r);
      chk(d[0], newer_variant);
   endtask
   initial begin
      mem_u.dly = 1;
      rst(1'b0);
      sc_paths();
      sc_faults();
      walk(32'h0055_503f, '0, ACC_LOAD, 1'b0, FC_NONE, 32'h0055_5abc, 1'b1, 1'b0);
      sc_regs();
      mem_u.dly = 7;
      rst(1'b1);
      // bit 5 set selects cache bypass for the newer encoding
      walk(32'h0055_503f, '0, ACC_STORE, 1'b0, FC_NONE, 32'h0055_5abc, 1'b0, 1'b1);
      sc_paths();
      sc_regs();
      summarize();
   end
endmodule
